// >>> src/irq_ctrl.sv
`timescale 1ns/10ps
module irq_ctrl (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     priority_scheme_enable_i,
  input  wire logic                     gate_wr_i,
  input  wire logic [1:0]               gate_wdata_i,
  input  wire irq_ctrl_pkg::src_vec_t   enable_i,
  input  wire irq_ctrl_pkg::src_vec_t   priority_i,
  input  wire irq_ctrl_pkg::src_vec_t   flag_clr_i,
  input  wire logic [3:0]               ext_pin_i,
  input  wire logic [3:0]               ext_edge_select_i,
  input  wire logic [3:0]               second_io_port_i,
  input  wire logic                     timer_event_i,
  input  wire logic [7:0]               periph_event_i,
  input  wire logic                     return_from_handler_instruction_i,
  output      irq_ctrl_pkg::src_vec_t   flags_o,
  output      logic                     master_irq_gate_o,
  output      logic                     peripheral_irq_gate_o,
  output      logic                     vector_valid_o,
  output      logic [15:0]              vector_addr_o,
  output      logic                     push_return_o,
  output      logic                     high_handler_active_o,
  output      logic                     low_handler_active_o
);
  import irq_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  irq_flag_if fl ();

  logic        arm_q;
  logic [3:0]  pin_prev_q;
  logic [3:0]  port_prev_q;
  logic [3:0]  pin_event;
  logic        port_change;
  logic [1:0]  div_q;
  logic        inst_tick;
  logic        gate_hi_q;
  logic        gate_lo_q;
  logic        prio_on;
  src_vec_t    pend;
  logic        hi_req;
  logic        lo_req;
  logic        accept;
  logic        acc_high_q;
  acc_state_e  state_q;
  logic [1:0]  wait_cnt_q;
  logic        vec_valid_q;
  logic [15:0] vec_addr_q;
  logic        high_act_q;
  logic        low_act_q;

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  // previous pin levels; arm_q masks the first cycle after reset,
  // otherwise a pin already high would look like a rising edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      arm_q       <= 1'b0;
      pin_prev_q  <= 4'h0;
      port_prev_q <= 4'h0;
    end else begin
      arm_q       <= 1'b1;
      pin_prev_q  <= ext_pin_i;
      port_prev_q <= second_io_port_i;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      if (ext_edge_select_i[i]) begin
        pin_event[i] = arm_q & ext_pin_i[i] & ~pin_prev_q[i];
      end else begin
        pin_event[i] = arm_q & ~ext_pin_i[i] & pin_prev_q[i];
      end
    end
  end

  assign port_change = arm_q & (|(second_io_port_i ^ port_prev_q));

  // ---------------------------------------------------------------
  // flag bank
  // ---------------------------------------------------------------
  // flag per source
  assign fl.set_ev = {periph_event_i, timer_event_i, port_change, pin_event};
  assign fl.clr    = flag_clr_i;
  assign flags_o   = fl.flags;

  irq_flag_bank u_flags (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .fl        (fl.bank)
  );

  // ---------------------------------------------------------------
  // instruction cycle divider
  // ---------------------------------------------------------------
  // requests are sampled once per instruction cycle, which makes the
  // latency independent of the length of the interrupted instruction
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_q <= 2'h0;
    end else if (div_q == INST_LAST) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  assign inst_tick = (div_q == INST_LAST);

  // ---------------------------------------------------------------
  // request qualification
  // ---------------------------------------------------------------
  // control words arrive as plain ports
  assign prio_on = priority_scheme_enable_i;
  assign pend    = fl.flags & enable_i;

  always_comb begin
    if (prio_on) begin
      hi_req = gate_hi_q & (|(pend & priority_i));
      lo_req = gate_hi_q & gate_lo_q & (|(pend & ~priority_i)) & ~high_act_q;
    end else begin
      hi_req = gate_hi_q & ((|(pend & CORE_MASK)) | (gate_lo_q & (|(pend & PERIPH_MASK))));
      lo_req = 1'b0;
    end
  end

  assign accept = (state_q == ST_IDLE) & inst_tick & (hi_req | lo_req);

  // ---------------------------------------------------------------
  // global gates
  // ---------------------------------------------------------------
  // software write first, return next, acceptance last: a clear on
  // acceptance must win or the same request would be taken twice
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gate_hi_q <= GATE_RST[1];
      gate_lo_q <= GATE_RST[0];
    end else begin
      if (gate_wr_i) begin
        gate_hi_q <= gate_wdata_i[1];
        gate_lo_q <= gate_wdata_i[0];
      end
      if (return_from_handler_instruction_i) begin
        if (!prio_on || high_act_q) begin
          gate_hi_q <= 1'b1;
        end else if (low_act_q) begin
          gate_lo_q <= 1'b1;
        end
      end
      if (accept) begin
        if (hi_req) begin
          gate_hi_q <= 1'b0;
        end else begin
          gate_lo_q <= 1'b0;
        end
      end
    end
  end

  assign master_irq_gate_o     = gate_hi_q;
  assign peripheral_irq_gate_o = gate_lo_q;

  // ---------------------------------------------------------------
  // acceptance sequencer
  // ---------------------------------------------------------------
  // fixed wait of three instruction ticks
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q    <= ST_IDLE;
      wait_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          wait_cnt_q <= 2'h0;
          if (accept) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (inst_tick) begin
            wait_cnt_q <= wait_cnt_q + 2'h1;
            if (wait_cnt_q == LAT_WAIT_INST - 2'h1) begin
              state_q <= ST_VECT;
            end
          end
        end
        ST_VECT: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      acc_high_q <= 1'b0;
      vec_addr_q <= VEC_HIGH;
    end else if (accept) begin
      acc_high_q <= hi_req;
      vec_addr_q <= (hi_req || !prio_on) ? VEC_HIGH : VEC_LOW;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      vec_valid_q <= 1'b0;
    end else begin
      vec_valid_q <= (state_q == ST_WAIT) & inst_tick
                     & (wait_cnt_q == LAT_WAIT_INST - 2'h1);
    end
  end

  assign vector_valid_o = vec_valid_q;
  assign vector_addr_o  = vec_addr_q;
  assign push_return_o  = vec_valid_q;

  // ---------------------------------------------------------------
  // handler tracking
  // ---------------------------------------------------------------
  // high may nest over low
  // a return unwinds the innermost level only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      high_act_q <= 1'b0;
      low_act_q  <= 1'b0;
    end else begin
      if (return_from_handler_instruction_i) begin
        if (high_act_q) begin
          high_act_q <= 1'b0;
        end else begin
          low_act_q <= 1'b0;
        end
      end
      if (vec_valid_q) begin
        if (acc_high_q) begin
          high_act_q <= 1'b1;
        end else begin
          low_act_q <= 1'b1;
        end
      end
    end
  end

  assign high_handler_active_o = high_act_q;
  assign low_handler_active_o  = low_act_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // high vector address
  AST_VEC_HIGH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (vector_valid_o && acc_high_q) |-> (vector_addr_o == VEC_HIGH))
    else $error("high vector address wrong");

  AST_VEC_LOW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (vector_valid_o && !acc_high_q) |-> (vector_addr_o == VEC_LOW))
    else $error("low vector address wrong");

  AST_COMPAT_VEC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (accept && !prio_on) |-> ##13 (vector_valid_o && vector_addr_o == VEC_HIGH))
    else $error("compatibility vector wrong");

  AST_GATE_CLR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (accept && !return_from_handler_instruction_i)
      |=> ($past(hi_req) ? !gate_hi_q : !gate_lo_q))
    else $error("gate not cleared on acceptance");

  AST_NO_LOW_IN_HIGH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (high_act_q && prio_on && accept) |=> acc_high_q)
    else $error("low request live inside high handler");

  AST_LATENCY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    accept |-> (!vector_valid_o)[*8] ##6 vector_valid_o)
    else $error("vector latency wrong");

  AST_PREEMPT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (low_act_q && prio_on && hi_req && state_q == ST_IDLE && inst_tick)
      |=> (state_q == ST_WAIT && acc_high_q))
    else $error("high request did not preempt");

  AST_RETURN_GATE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (return_from_handler_instruction_i && high_act_q && !accept && !gate_wr_i)
      |=> gate_hi_q)
    else $error("return did not restore gate");

  AST_ENABLE_MASK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ((fl.flags & enable_i) == '0) |-> !accept)
    else $error("acceptance without an enabled flag");

  AST_PUSH_PULSE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    push_return_o |=> !push_return_o)
    else $error("push strobe longer than one cycle");

endmodule // irq_ctrl

// >>> src/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ---------------------------------------------------------------
  // source map
  // ---------------------------------------------------------------
  localparam int NUM_EXT    = 4;
  localparam int NUM_PERIPH = 8;
  localparam int NUM_SRC    = 14;
  localparam int SRC_EXT0   = 0;  // external pins take 0..3
  localparam int SRC_PORTCH = 4;  // upper port nibble change
  localparam int SRC_TIMER  = 5;  // core timer overflow
  localparam int SRC_PERIPH = 6;  // peripherals take 6..13

  typedef logic [NUM_SRC-1:0] src_vec_t;

  // peripheral sources sit behind the peripheral gate in compatibility mode
  localparam src_vec_t PERIPH_MASK = 14'h3fc0;
  localparam src_vec_t CORE_MASK   = 14'h003f;

  // ---------------------------------------------------------------
  // vectors and gate bit positions
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_HIGH      = 16'h0008;
  localparam logic [15:0] VEC_LOW       = 16'h0018;
  localparam int          GATE_HI_BIT   = 7;  // master / high gate
  localparam int          GATE_LO_BIT   = 6;  // peripheral / low gate
  localparam int          PRIO_EN_BIT   = 7;  // bit in the reset control register
  localparam logic [1:0]  GATE_RST      = 2'h0;
  localparam src_vec_t    FLAG_RST      = 14'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          INST_PERIOD_NS = 40;
  localparam int          CLK_PER_INST   = INST_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  INST_LAST      = 2'(CLK_PER_INST - 1);
  localparam logic [1:0]  LAT_WAIT_INST  = 2'h3;  // instruction ticks after acceptance

  // acceptance sequencer, gray along idle -> wait -> vector
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_VECT = 2'b11
  } acc_state_e;

endpackage

// >>> src/irq_flag_if.sv
`timescale 1ns/10ps
// event and clear strobes into the flag bank, flags back out
interface irq_flag_if;
  import irq_ctrl_pkg::*;
  src_vec_t set_ev;
  src_vec_t clr;
  src_vec_t flags;
  modport ctrl (output set_ev, output clr, input flags);
  modport bank (input set_ev, input clr, output flags);
endinterface

// >>> src/irq_flag_bank.sv
`timescale 1ns/10ps
module irq_flag_bank (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  irq_flag_if.bank  fl
);
  import irq_ctrl_pkg::*;

  src_vec_t flag_q;

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  // set regardless of enables
  // an event in the clear cycle survives, so set wins over clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flag_q <= FLAG_RST;
    end else begin
      flag_q <= (flag_q & ~fl.clr) | fl.set_ev;
    end
  end

  assign fl.flags = flag_q;

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (fl.set_ev != '0) |=> ((fl.flags & $past(fl.set_ev)) == $past(fl.set_ev)))
    else $error("flag event lost");

endmodule // irq_flag_bank

// >>> verif/core_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// core fetch and stack stand-in
// ---------------------------------------------------------------
module core_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        vector_valid_i,
  input  wire logic [15:0] vector_addr_i,
  input  wire logic        push_return_i,
  input  wire logic        ret_req_i,
  output      logic [15:0] pc_o,
  output      logic [3:0]  depth_o,
  output      logic        ret_o
);
  logic [15:0] stack_q [8];
  // push then load
  // pc just walks between vectors, enough to see the stack unwind
  always_ff @(posedge clk_i) begin
    ret_o <= 1'b0;
    if (!reset_n_i) begin
      pc_o    <= 16'h0100;
      depth_o <= 4'h0;
    end else if (push_return_i && vector_valid_i) begin
      stack_q[depth_o[2:0]] <= pc_o;
      depth_o               <= depth_o + 4'h1;
      pc_o                  <= vector_addr_i;
    end else if (ret_req_i && depth_o != 4'h0) begin
      ret_o   <= 1'b1;
      depth_o <= depth_o - 4'h1;
      pc_o    <= stack_q[depth_o[2:0] - 3'h1];
    end else begin
      pc_o <= pc_o + 16'h0002;
    end
  end
endmodule // core_model

// >>> verif/two_level_priority_interrupt_ctrl_tb.sv
`timescale 1ns/10ps
module two_level_priority_interrupt_ctrl_tb;
  import irq_ctrl_pkg::*;
  typedef struct packed {
    logic        prio;
    logic [1:0]  gates;
    logic [3:0]  src;
    logic        hi;
    logic        en;
    logic        sel;
    logic        fire;
    logic [15:0] addr;
    logic [1:0]  gaft;
  } row_s;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_i;
  logic        reset_n_i;
  logic        prio_en;
  logic        gate_wr;
  logic [1:0]  gate_wd;
  src_vec_t    enable;
  src_vec_t    prio_vec;
  src_vec_t    flag_clr;
  src_vec_t    flags;
  logic [3:0]  ext_pin;
  logic [3:0]  ext_sel;
  logic [3:0]  port;
  logic        timer;
  logic [7:0]  periph;
  logic        ret_req;
  logic        ret_pulse;
  logic        mgate;
  logic        pgate;
  logic        vvalid;
  logic [15:0] vaddr;
  logic        push;
  logic        hact;
  logic        lact;
  logic [15:0] pc;
  logic [3:0]  depth;
  int          bad_count;
  int          total_checks;
  int          cyc;
  int          n;
  row_s        rows [11] = '{
    '{1'h0, 2'h2, 4'h0, 1'h0, 1'h1, 1'h1, 1'h1, VEC_HIGH, 2'h0},
    '{1'h0, 2'h2, 4'h1, 1'h1, 1'h1, 1'h0, 1'h1, VEC_HIGH, 2'h0},
    '{1'h0, 2'h2, 4'h4, 1'h0, 1'h1, 1'h0, 1'h1, VEC_HIGH, 2'h0},
    '{1'h0, 2'h2, 4'h6, 1'h0, 1'h1, 1'h0, 1'h0, VEC_HIGH, 2'h2},
    '{1'h0, 2'h3, 4'hd, 1'h0, 1'h1, 1'h0, 1'h1, VEC_HIGH, 2'h1},
    '{1'h1, 2'h3, 4'h5, 1'h1, 1'h1, 1'h0, 1'h1, VEC_HIGH, 2'h1},
    '{1'h1, 2'h3, 4'hd, 1'h0, 1'h1, 1'h0, 1'h1, VEC_LOW,  2'h2},
    '{1'h1, 2'h1, 4'h5, 1'h1, 1'h1, 1'h0, 1'h0, VEC_HIGH, 2'h1},
    '{1'h1, 2'h2, 4'h2, 1'h0, 1'h1, 1'h1, 1'h0, VEC_HIGH, 2'h2},
    '{1'h1, 2'h3, 4'h3, 1'h1, 1'h0, 1'h1, 1'h0, VEC_HIGH, 2'h3},
    '{1'h1, 2'h2, 4'h7, 1'h1, 1'h1, 1'h0, 1'h1, VEC_HIGH, 2'h0}};
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  irq_ctrl i_irq_ctrl (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .priority_scheme_enable_i(prio_en),
    .gate_wr_i(gate_wr), .gate_wdata_i(gate_wd), .enable_i(enable),
    .priority_i(prio_vec), .flag_clr_i(flag_clr), .ext_pin_i(ext_pin),
    .ext_edge_select_i(ext_sel), .second_io_port_i(port), .timer_event_i(timer),
    .periph_event_i(periph), .return_from_handler_instruction_i(ret_pulse),
    .flags_o(flags), .master_irq_gate_o(mgate), .peripheral_irq_gate_o(pgate),
    .vector_valid_o(vvalid), .vector_addr_o(vaddr), .push_return_o(push),
    .high_handler_active_o(hact), .low_handler_active_o(lact));
  core_model i_core_model (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .vector_valid_i(vvalid),
    .vector_addr_i(vaddr), .push_return_i(push), .ret_req_i(ret_req),
    .pc_o(pc), .depth_o(depth), .ret_o(ret_pulse));
  // ---------------------------------------------------------------
  // tasks, entered just after a falling edge, except test_done from the timeout on a rising edge
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic do_reset();
    reset_n_i = 1'b0;
    tick(2);
    reset_n_i = 1'b1;
    tick(1);
  endtask
  // whole gate word changes in one write
  task automatic wgates(input logic [1:0] g);
    gate_wd = g;
    gate_wr = 1'b1;
    tick(1);
    gate_wr = 1'b0;
  endtask
  task automatic clr(input src_vec_t m);
    flag_clr = m;
    tick(1);
    flag_clr = '0;
  endtask
  task automatic ret();
    ret_req = 1'b1;
    tick(1);
    ret_req = 1'b0;
    tick(3);
  endtask
  task automatic fire(input logic [3:0] s, input logic sel);
    if (s < 4'h4) ext_pin[s[1:0]] = sel;
    else if (s == 4'h4) port[3] = ~port[3];
    else if (s == 4'h5) timer = 1'b1;
    else periph[s - 4'h6] = 1'b1;
  endtask
  // event pulses last one cycle; the wait is bounded at 30 cycles
  task automatic wait_vec(output int k);
    k = 0;
    do begin
      tick(1);
      timer = 1'b0;
      periph = 8'h0;
      k++;
    end while (vvalid !== 1'b1 && k < 30);
  endtask
  task automatic run_row(input row_s r);
    int k;
    ext_pin = {4{~r.sel}};
    ext_sel = {4{r.sel}};
    do_reset();
    prio_en = r.prio;
    enable = src_vec_t'(r.en) << r.src;
    prio_vec = src_vec_t'(r.hi) << r.src;
    wgates(r.gates);
    tick(2);
    fire(r.src, r.sel);
    wait_vec(k);
    chk("vector", {15'h0, vvalid}, {15'h0, r.fire}); // gating
    if (r.fire) begin
      chk("latency", {15'h0, k >= 14 && k <= 17}, 16'h1); // event to vector
      chk("vaddr", vaddr, r.addr); // vector choice
      chk("push", {15'h0, push}, 16'h1); // push with vector
      tick(1);
      chk("pc", pc, r.addr); // pc loaded
    end
    chk("gates", {14'h0, mgate, pgate}, {14'h0, r.gaft}); // gate cleared
    chk("flag", {15'h0, flags[r.src]}, 16'h1); // flag set
    if (r.fire) begin
      clr(flags);
      ret();
      chk("gates back", {14'h0, mgate, pgate}, {14'h0, r.gates}); // gate restored
      chk("idle", {14'h0, hact, lact}, 16'h0); // handler left
    end
  endtask
  // ---------------------------------------------------------------
  // clock, timeout and stimulus
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // a hang ends the run as a mismatch
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    {reset_n_i, prio_en, gate_wr, gate_wd, timer, periph, ret_req} = '0;
    {enable, prio_vec, flag_clr, ext_pin, ext_sel, port} = '0;
    {bad_count, total_checks, cyc} = '0;
    tick(12);
    reset_n_i = 1'b1;
    tick(1);
    chk("flags rst", {2'h0, flags}, 16'h0);
    chk("gates rst", {13'h0, mgate, pgate, vvalid}, 16'h0);
    chk("vaddr rst", vaddr, VEC_HIGH);
    foreach (rows[i]) run_row(rows[i]);
    // simultaneous high and low, then nesting
    ext_sel = 4'hf;
    do_reset();
    prio_en = 1'b1;
    enable = 14'h0060;
    prio_vec = 14'h0020;
    wgates(2'h3);
    tick(2);
    fire(4'h5, 1'b0);
    fire(4'h6, 1'b0);
    wait_vec(n);
    chk("first", vaddr, VEC_HIGH); // high taken first
    tick(1);
    clr(14'h0020);
    wgates(2'h3);
    wait_vec(n);
    chk("low held", {15'h0, vvalid}, 16'h0); // low held off
    ret();
    wait_vec(n);
    chk("pending low", vaddr, VEC_LOW); // low left pending
    tick(1);
    chk("low active", {14'h0, hact, lact}, 16'h1); // low handler runs
    fire(4'h5, 1'b0);
    wait_vec(n);
    chk("preempt", vaddr, VEC_HIGH); // high preempts low
    tick(2);
    chk("nested", {12'h0, depth}, 16'h2); // two returns stacked
    chk("both active", {14'h0, hact, lact}, 16'h3); // both handlers live
    clr(14'h0060);
    ret();
    ret();
    chk("unwound", {12'h0, depth}, 16'h0); // both handlers left
    chk("gates end", {14'h0, mgate, pgate}, 16'h3); // both gates set
    test_done();
  end
endmodule // two_level_priority_interrupt_ctrl_tb
